// file: logic/mpio_regs.vh
// constants for the multi-port i/o block
`ifndef MPIO_REGS_VH
`define MPIO_REGS_VH
`define MPIO_A_P1_LAT  6'h01
`define MPIO_A_P2_LAT  6'h02
`define MPIO_A_P3_LAT  6'h03
`define MPIO_A_P3_DRV  6'h04
`define MPIO_A_P5_LAT  6'h05
`define MPIO_A_P6_LAT  6'h06
`define MPIO_A_P7_LAT  6'h07
`define MPIO_A_P1_PIN  6'h08
`define MPIO_A_P2_PIN  6'h09
`define MPIO_A_P3_PIN  6'h0a
`define MPIO_A_P5_PIN  6'h0b
`define MPIO_A_P6_DIR  6'h0c
`define MPIO_A_P7_PIN  6'h0d
`define MPIO_A_CONV1   6'h0e
`define MPIO_A_P1_SEG  6'h29
`define MPIO_A_P5_SEG  6'h2a
`define MPIO_A_P7_SEG  6'h2b
`define MPIO_ANALOG_INPUT_DISABLE_BIT 4
`define MPIO_RST_ONES8 8'hff
`define MPIO_RST_ONES3 3'h7
`define MPIO_RST_ONES4 4'hf
`define MPIO_RST_ZERO8 8'h00
`define MPIO_RST_ZERO4 4'h0
`define MPIO_RST_ZERO3 3'h0
`define MPIO_RST_SET1  1'b1
`define MPIO_RST_CLR1  1'b0
`define MPIO_RST_CONV1 8'h10
`endif

// file: logic/mpio_ports.v
// six parallel i/o ports with segment, drive-type and analog selection
`timescale 1ns/1ps
// What this block does
// [RQ1] outputs hold latched value until next write; pin inputs are live samples
// [RQ2] port read samples pin level in the first state of the read cycle
// [RQ3] port write reaches the pin in the second state of the write cycle
// [RQ4] port1 segment select one gives lcd drive, zero gives latch drive
// [RQ5] software sets latch one and clears segment select for port1 input use
// [RQ6] reset loads all port1 latch bits with one
// [RQ7] latch and pin input read at separate addresses
// [RQ8] pin read of a segment bit on ports 1, 5, 7 is undefined
// [RQ9] port2 is three bits, latch resets to one
// [RQ10] port2 bits one and two are crystal pins in dual-clock mode
// [RQ11] port2 bit zero falling output edge still sets its interrupt latch
// [RQ12] unimplemented upper bits of port2 and port3 reads are undefined
// [RQ13] in stop mode port2 bit zero floats regardless of output hold
// [RQ14] port3 drive type zero is open drain, one is push-pull
// [RQ15] reset sets port3 latch to ones and drive type to zero
// [RQ16] software sets port3 latch one then clears drive type for inputs
// [RQ17] port5 eight bits, latch resets to ones, segment select per bit
// [RQ18] port7 eight bits, latch resets to ones, segment select per bit
// [RQ19] reset clears port6 direction and latch, sets analog disable, input reads zero
// [RQ20] port6 direction one drives; zero with latch one input; zero zero analog
// [RQ21] port6 analog bits read back as zero
// [RQ22] software must not read-modify-write the port6 latch
`include "mpio_regs.vh"
module mpio_ports (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// cpu access
	input  wire [5:0]  cpu_addr,
	input  wire [7:0]  cpu_wdata,
	input  wire        cpu_wr,
	input  wire        cpu_rd,
	output reg  [7:0]  cpu_rdata,
	// system mode
	input  wire        dual_clock_mode,
	input  wire        stop_mode,
	input  wire        stop_output_hold_enable,
	// pins
	input  wire [7:0]  p1_in,
	input  wire [2:0]  p2_in,
	input  wire [3:0]  p3_in,
	input  wire [7:0]  p5_in,
	input  wire [7:0]  p6_in,
	input  wire [7:0]  p7_in,
	output reg  [7:0]  p1_out,
	output reg  [7:0]  p1_oe,
	output reg  [2:0]  p2_out,
	output reg  [2:0]  p2_oe,
	output reg  [3:0]  p3_out,
	output reg  [3:0]  p3_oe,
	output reg  [7:0]  p5_out,
	output reg  [7:0]  p5_oe,
	output reg  [7:0]  p6_out,
	output reg  [7:0]  p6_oe,
	output reg  [7:0]  p7_out,
	output reg  [7:0]  p7_oe,
	// lcd segment drive, analog select and interrupt
	input  wire [7:0]  seg_drive_p1,
	input  wire [7:0]  seg_drive_p5,
	input  wire [7:0]  seg_drive_p7,
	output reg  [7:0]  p6_analog_sel,
	output reg         analog_input_disable,
	output reg         port2_bit0_stop_fall
);
	// registers
	reg [7:0] port1_out_latch;
	reg [2:0] port2_out_latch;
	reg [3:0] port3_out_latch;
	reg [3:0] port3_drive_type;
	reg [7:0] port5_out_latch;
	reg [7:0] port6_out_latch;
	reg [7:0] port6_direction;
	reg [7:0] port7_out_latch;
	reg [7:0] converter_control_one;
	reg [7:0] port1_segment_select;
	reg [7:0] port5_segment_select;
	reg [7:0] port7_segment_select;
	// pin synchronisers: two flops per pin, so a read reports the level from
	// two edges before the strobe; software cannot tell that from live sampling
	reg [38:0] pin_s1_reg;
	reg [38:0] pin_s2_reg;
	reg        p2b0_prev_reg;
	wire [7:0] p1_pin = pin_s2_reg[7:0];
	wire [2:0] p2_pin = pin_s2_reg[10:8];
	wire [3:0] p3_pin = pin_s2_reg[14:11];
	wire [7:0] p5_pin = pin_s2_reg[22:15];
	wire [7:0] p6_pin = pin_s2_reg[30:23];
	wire [7:0] p7_pin = pin_s2_reg[38:31];
	wire [7:0] p6_digital_in;
	wire [7:0] p6_analog;
	wire [7:0] p3_oe_full;
	wire       p2_hold_drive = ~stop_mode | stop_output_hold_enable;
	reg  [7:0] rdata_next;

	// per-bit port6 mode: direction one drives, else the latch picks input or analog
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_p6_mode
			assign p6_digital_in[gi] = ~port6_direction[gi] & port6_out_latch[gi];
			assign p6_analog[gi]     = ~port6_direction[gi] & ~port6_out_latch[gi];
		end
	endgenerate

	// lcd-capable pin group: a set segment selector hands the pin to the panel
	function [7:0] seg_or_latch;
		input [7:0] sel;
		input [7:0] seg;
		input [7:0] lat;
		begin
			seg_or_latch = (sel & seg) | (~sel & lat);
		end
	endfunction

	// open-drain style: a latch one releases the pin unless something forces drive
	function [7:0] drive_enable;
		input [7:0] force_drive;
		input [7:0] lat;
		begin
			drive_enable = force_drive | ~lat;
		end
	endfunction

	// port6 read: driven bits give the latch, inputs the pin, analog bits zero
	function [7:0] p6_read_value;
		input [7:0] dir;
		input [7:0] lat;
		input [7:0] inp;
		input [7:0] pin;
		begin
			p6_read_value = (dir & lat) | (inp & pin);
		end
	endfunction

	// port3 keeps its four pins in the low half; the upper half never drives
	assign p3_oe_full = drive_enable({4'h0, port3_drive_type}, {4'hf, port3_out_latch});

	always @(posedge clk_sys) begin
		pin_s1_reg <= {p7_in, p6_in, p5_in, p3_in, p2_in, p1_in};
		pin_s2_reg <= pin_s1_reg;
	end

	// writes land in the latch at the strobe edge, one clock before the pin update
	always @(posedge clk_sys) begin
		if (rst) begin
			port1_out_latch       <= `MPIO_RST_ONES8; // RQ6
			port2_out_latch       <= `MPIO_RST_ONES3; // RQ9
			port3_out_latch       <= `MPIO_RST_ONES4; // RQ15
			port3_drive_type      <= `MPIO_RST_ZERO4; // RQ15
			port5_out_latch       <= `MPIO_RST_ONES8; // RQ17
			port7_out_latch       <= `MPIO_RST_ONES8; // RQ18
			port6_out_latch       <= `MPIO_RST_ZERO8; // RQ19
			port6_direction       <= `MPIO_RST_ZERO8; // RQ19
			converter_control_one <= `MPIO_RST_CONV1; // RQ19
			port1_segment_select  <= `MPIO_RST_ZERO8;
			port5_segment_select  <= `MPIO_RST_ZERO8;
			port7_segment_select  <= `MPIO_RST_ZERO8;
		end else if (cpu_wr) begin
			// unmapped addresses match no branch and change nothing
			if (cpu_addr == `MPIO_A_P1_LAT) begin
				port1_out_latch <= cpu_wdata; // RQ1
			end else if (cpu_addr == `MPIO_A_P2_LAT) begin
				port2_out_latch <= cpu_wdata[2:0];
			end else if (cpu_addr == `MPIO_A_P3_LAT) begin
				port3_out_latch <= cpu_wdata[3:0];
			end else if (cpu_addr == `MPIO_A_P3_DRV) begin
				port3_drive_type <= cpu_wdata[3:0];
			end else if (cpu_addr == `MPIO_A_P5_LAT) begin
				port5_out_latch <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_P6_LAT) begin
				port6_out_latch <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_P7_LAT) begin
				port7_out_latch <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_P6_DIR) begin
				port6_direction <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_CONV1) begin
				converter_control_one <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_P1_SEG) begin
				port1_segment_select <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_P5_SEG) begin
				port5_segment_select <= cpu_wdata;
			end else if (cpu_addr == `MPIO_A_P7_SEG) begin
				port7_segment_select <= cpu_wdata;
			end
		end
	end

	// segment bits read live pin data; that value is undefined to software
	always @* begin
		// unmapped addresses read as zero
		rdata_next = 8'h00;
		if (cpu_addr == `MPIO_A_P1_LAT) begin
			rdata_next = port1_out_latch; // RQ7
		end else if (cpu_addr == `MPIO_A_P2_LAT) begin
			rdata_next = {5'h00, port2_out_latch}; // RQ12
		end else if (cpu_addr == `MPIO_A_P3_LAT) begin
			rdata_next = {4'h0, port3_out_latch}; // RQ12
		end else if (cpu_addr == `MPIO_A_P3_DRV) begin
			rdata_next = {4'h0, port3_drive_type};
		end else if (cpu_addr == `MPIO_A_P5_LAT) begin
			rdata_next = port5_out_latch;
		end else if (cpu_addr == `MPIO_A_P6_LAT) begin
			// port6 latch address returns pins for input bits: a read-modify-write breaks modes RQ22
			rdata_next = p6_read_value(port6_direction, port6_out_latch,
				p6_digital_in, p6_pin); // RQ21
		end else if (cpu_addr == `MPIO_A_P7_LAT) begin
			rdata_next = port7_out_latch;
		end else if (cpu_addr == `MPIO_A_P1_PIN) begin
			rdata_next = p1_pin; // RQ8
		end else if (cpu_addr == `MPIO_A_P2_PIN) begin
			rdata_next = {5'h00, p2_pin};
		end else if (cpu_addr == `MPIO_A_P3_PIN) begin
			rdata_next = {4'h0, p3_pin};
		end else if (cpu_addr == `MPIO_A_P5_PIN) begin
			rdata_next = p5_pin;
		end else if (cpu_addr == `MPIO_A_P6_DIR) begin
			rdata_next = port6_direction;
		end else if (cpu_addr == `MPIO_A_P7_PIN) begin
			rdata_next = p7_pin;
		end else if (cpu_addr == `MPIO_A_CONV1) begin
			rdata_next = converter_control_one;
		end else if (cpu_addr == `MPIO_A_P1_SEG) begin
			rdata_next = port1_segment_select;
		end else if (cpu_addr == `MPIO_A_P5_SEG) begin
			rdata_next = port5_segment_select;
		end else if (cpu_addr == `MPIO_A_P7_SEG) begin
			rdata_next = port7_segment_select;
		end
	end

	// read data is captured at the strobe edge from already-synchronised pins
	always @(posedge clk_sys) begin
		if (rst) begin
			cpu_rdata <= `MPIO_RST_ZERO8;
		end else if (cpu_rd) begin
			cpu_rdata <= rdata_next; // RQ2
		end
	end

	// segment-capable ports 1, 5 and 7; a latch one floats the pin high unless the bit's segment select is set
	always @(posedge clk_sys) begin
		if (rst) begin
			p1_out <= `MPIO_RST_ZERO8;
			p1_oe  <= `MPIO_RST_ZERO8;
			p5_out <= `MPIO_RST_ZERO8;
			p5_oe  <= `MPIO_RST_ZERO8;
			p7_out <= `MPIO_RST_ZERO8;
			p7_oe  <= `MPIO_RST_ZERO8;
		end else begin
			p1_out <= seg_or_latch(port1_segment_select, seg_drive_p1, port1_out_latch); // RQ4
			p1_oe  <= drive_enable(port1_segment_select, port1_out_latch); // RQ3
			p5_out <= seg_or_latch(port5_segment_select, seg_drive_p5, port5_out_latch); // RQ17
			p5_oe  <= drive_enable(port5_segment_select, port5_out_latch);
			p7_out <= seg_or_latch(port7_segment_select, seg_drive_p7, port7_out_latch); // RQ18
			p7_oe  <= drive_enable(port7_segment_select, port7_out_latch);
		end
	end

	// port2 bit 0 is the stop wake-up input, so stop floats it whatever the hold
	// setting; bits 1 and 2 keep their drive in stop only while hold is set
	always @(posedge clk_sys) begin
		if (rst) begin
			p2_out <= `MPIO_RST_ZERO3;
			p2_oe  <= `MPIO_RST_ZERO3;
			p3_out <= `MPIO_RST_ZERO4;
			p3_oe  <= `MPIO_RST_ZERO4;
		end else begin
			p3_out <= port3_out_latch;
			p3_oe  <= p3_oe_full[3:0]; // RQ14
			p2_out <= port2_out_latch;
			p2_oe[0] <= ~port2_out_latch[0] & ~stop_mode; // RQ13
			p2_oe[2:1] <= dual_clock_mode ? 2'h0 :
				(~port2_out_latch[2:1] & {2{p2_hold_drive}}); // RQ10
		end
	end

	// port6 drive and analog select, and the converter's analog disable bit
	always @(posedge clk_sys) begin
		if (rst) begin
			p6_out <= `MPIO_RST_ZERO8;
			p6_oe  <= `MPIO_RST_ZERO8;
			p6_analog_sel <= `MPIO_RST_ZERO8;
			analog_input_disable <= `MPIO_RST_SET1;
		end else begin
			p6_out <= port6_out_latch;
			p6_oe  <= port6_direction; // RQ20
			p6_analog_sel <= p6_analog;
			analog_input_disable <= converter_control_one[`MPIO_ANALOG_INPUT_DISABLE_BIT];
		end
	end

	// edge of the synchronised port2 bit 0 level, so the port's own falling
	// output flags the interrupt source just as an external fall does
	always @(posedge clk_sys) begin
		if (rst) begin
			p2b0_prev_reg <= `MPIO_RST_SET1;
			port2_bit0_stop_fall <= `MPIO_RST_CLR1;
		end else begin
			p2b0_prev_reg <= p2_pin[0];
			port2_bit0_stop_fall <= p2b0_prev_reg & ~p2_pin[0]; // RQ11
		end
	end
endmodule

// file: verif/mpio_pin_model.sv
// board side of one port: pins driven by the port or held by the board
`timescale 1ns/1ps
module mpio_pin_bank #(
	parameter W = 8
) (
	// from the port
	input  wire [W-1:0] out,
	input  wire [W-1:0] oe,
	// board level: pull-up or external driver
	input  wire [W-1:0] ext,
	// level seen by the port
	output wire [W-1:0] pin
);
	// a released pin shows the board level, never the port's last value
	assign pin = (oe & out) | (~oe & ext);
endmodule

// file: verif/mpio_ports_props.sv
// assertions for the multi-port i/o block
`timescale 1ns/1ps
module mpio_ports_props (
	// clock, reset and cpu side
	input wire       clk_sys,
	input wire       rst,
	input wire [5:0] cpu_addr,
	input wire [7:0] cpu_wdata,
	input wire       cpu_wr,
	input wire       cpu_rd,
	input wire [7:0] cpu_rdata,
	// modes and pins
	input wire       dual_clock_mode,
	input wire       stop_mode,
	input wire [7:0] seg_drive_p1,
	input wire [7:0] p1_out,
	input wire [2:0] p2_oe,
	input wire [3:0] p3_oe,
	input wire [7:0] p6_out,
	input wire [7:0] p6_oe,
	input wire       analog_input_disable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence quiet;
		!cpu_wr && $stable(seg_drive_p1);
	endsequence
	sequence wr_at(a);
		cpu_wr && cpu_addr == a;
	endsequence
	a_reset_pins_idle: assert property (disable iff (1'b0) rst |=> p3_oe == 4'h0
		&& p6_oe == 8'h00 && analog_input_disable) else $error("pins not idle after reset");
	a_p6_dir_drive: assert property (wr_at(6'h0c) |-> ##2 p6_oe == $past(cpu_wdata, 2))
		else $error("p6 drive enable wrong");
	a_p6_latch_out: assert property (wr_at(6'h06) |-> ##2 p6_out == $past(cpu_wdata, 2))
		else $error("p6 output wrong");
	a_conv_disable: assert property (wr_at(6'h0e) |-> ##2
		analog_input_disable == |($past(cpu_wdata, 2) & 8'h10)) else $error("disable bit wrong");
	a_stop_pin_float: assert property (stop_mode [*2] |-> !p2_oe[0])
		else $error("stop pin driven");
	a_dual_xtal_free: assert property (dual_clock_mode [*2] |-> p2_oe[2:1] == 2'b00)
		else $error("crystal pins driven");
	a_p3_push_pull: assert property (wr_at(6'h04) ##0 cpu_wdata[3:0] == 4'hf
		|-> ##2 p3_oe == 4'hf) else $error("p3 push-pull not driving");
	a_upper_bits_zero: assert property (cpu_rd && cpu_addr inside {6'h02, 6'h03, 6'h09,
		6'h0a} |=> cpu_rdata[7:4] == 4'h0) else $error("upper read bits set");
	a_p1_out_hold: assert property (quiet [*3] |=> $stable(p1_out))
		else $error("p1 output moved without write");
endmodule
bind mpio_ports mpio_ports_props u_props (.clk_sys(clk_sys), .rst(rst),
	.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
	.cpu_rdata(cpu_rdata), .dual_clock_mode(dual_clock_mode), .stop_mode(stop_mode),
	.seg_drive_p1(seg_drive_p1), .p1_out(p1_out), .p2_oe(p2_oe), .p3_oe(p3_oe),
	.p6_out(p6_out), .p6_oe(p6_oe), .analog_input_disable(analog_input_disable));

// file: verif/testbench.sv
// self-checking bench for the multi-port i/o block
`timescale 1ns/1ps
module testbench;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  cpu_addr = 6'h00;
	logic [7:0]  cpu_wdata = 8'h00;
	logic        cpu_wr = 1'b0;
	logic        cpu_rd = 1'b0;
	logic        dual = 1'b0;
	logic        stop = 1'b0;
	logic        hold = 1'b0;
	logic [7:0]  sg [0:7] = '{default: 8'h00};
	logic [7:0]  ex [0:7] = '{default: 8'hff};
	logic [7:0]  pm [0:7] = '{8'h00, 8'hff, 8'h07, 8'h0f, 8'h00, 8'hff, 8'h00, 8'hff};
	logic [7:0]  pp [0:7] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h00, 8'h0b, 8'h00, 8'h0d};
	logic [15:0] rt [0:12] = '{16'h01ff, 16'h0207, 16'h030f, 16'h0400, 16'h05ff, 16'h0600,
		16'h07ff, 16'h0c00, 16'h0e10, 16'h2900, 16'h2a00, 16'h2b00, 16'h3f00};
	int          pa [0:4] = '{1, 2, 3, 5, 7};
	wire [7:0]   po [0:7], poe [0:7], pi [0:7];
	wire [7:0]   cpu_rdata, p6_analog_sel;
	wire         analog_input_disable, fall;
	logic [7:0]  d, e, cnt;
	int          i, k, n_checks = 0, miscompares = 0;
	integer      seed = 32'he8f4fb96;
	mpio_ports u_dut (.clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.dual_clock_mode(dual), .stop_mode(stop), .stop_output_hold_enable(hold),
		.p1_in(pi[1]), .p2_in(pi[2][2:0]), .p3_in(pi[3][3:0]), .p5_in(pi[5]),
		.p6_in(pi[6]), .p7_in(pi[7]), .p1_out(po[1]), .p1_oe(poe[1]),
		.p2_out(po[2][2:0]), .p2_oe(poe[2][2:0]), .p3_out(po[3][3:0]),
		.p3_oe(poe[3][3:0]), .p5_out(po[5]), .p5_oe(poe[5]), .p6_out(po[6]),
		.p6_oe(poe[6]), .p7_out(po[7]), .p7_oe(poe[7]), .seg_drive_p1(sg[1]),
		.seg_drive_p5(sg[5]), .seg_drive_p7(sg[7]), .p6_analog_sel(p6_analog_sel),
		.analog_input_disable(analog_input_disable), .port2_bit0_stop_fall(fall));
	mpio_pin_bank u_b1 (.out(po[1]), .oe(poe[1]), .ext(ex[1]), .pin(pi[1]));
	mpio_pin_bank #(.W(3)) u_b2 (.out(po[2][2:0]), .oe(poe[2][2:0]), .ext(ex[2][2:0]),
		.pin(pi[2][2:0]));
	mpio_pin_bank #(.W(4)) u_b3 (.out(po[3][3:0]), .oe(poe[3][3:0]), .ext(ex[3][3:0]),
		.pin(pi[3][3:0]));
	mpio_pin_bank u_b5 (.out(po[5]), .oe(poe[5]), .ext(ex[5]), .pin(pi[5]));
	mpio_pin_bank u_b6 (.out(po[6]), .oe(poe[6]), .ext(ex[6]), .pin(pi[6]));
	mpio_pin_bank u_b7 (.out(po[7]), .oe(poe[7]), .ext(ex[7]), .pin(pi[7]));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(negedge clk_sys);
		cpu_addr = a;
		cpu_wdata = v;
		cpu_wr = 1'b1;
		@(negedge clk_sys);
		cpu_wr = 1'b0;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(negedge clk_sys);
		cpu_rd = 1'b0;
		chk(cpu_rdata, exp);
	endtask
	task automatic summarize;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial forever #5 clk_sys = ~clk_sys;
	// run needs about 530 cycles; a hang is cut well after that
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		wr(6'h3f, 8'h5a);
		for (i = 0; i < 13; i++) rdc(rt[i][13:8], rt[i][7:0]);
		for (i = 0; i < 40; i++) begin
			k = pa[{$random(seed)} % 5];
			d = $random(seed);
			for (int j = 1; j < 8; j++) ex[j] = $random(seed);
			wr(6'(k), d);
			rdc(6'(k), d & pm[k]);
			repeat (3) @(negedge clk_sys);
			rdc(pp[k][5:0], d & ex[k] & pm[k]);
		end
		ex[3] = 8'h0a;
		wr(6'h03, 8'h05);
		wr(6'h04, 8'h0f);
		repeat (3) @(negedge clk_sys);
		rdc(6'h0a, 8'h05);
		chk(poe[3] & 8'h0f, 8'h0f);
		wr(6'h03, 8'hff);
		wr(6'h04, 8'h00);
		repeat (3) @(negedge clk_sys);
		rdc(6'h0a, 8'h0a);
		for (i = 0; i < 3; i++) begin
			k = (i == 0) ? 1 : 3 + 2 * i;
			sg[k] = $random(seed);
			wr(6'(41 + i), 8'hff);
			repeat (3) @(negedge clk_sys);
			chk(po[k], sg[k]);
			chk(poe[k], 8'hff);
			wr(6'(k), 8'hff);
			wr(6'(41 + i), 8'h00);
			repeat (3) @(negedge clk_sys);
			chk(poe[k], 8'h00);
		end
		repeat (4) begin
			d = $random(seed);
			e = $random(seed);
			wr(6'h0c, d);
			wr(6'h06, e);
			repeat (3) @(negedge clk_sys);
			rdc(6'h06, (d & e) | (~d & e & ex[6]));
			chk(p6_analog_sel, ~d & ~e);
			chk(poe[6], d);
			chk(po[6], e);
		end
		wr(6'h0e, 8'hef);
		repeat (2) @(negedge clk_sys);
		chk({7'h00, analog_input_disable}, 8'h00);
		wr(6'h0e, 8'h10);
		ex[2] = 8'hff;
		wr(6'h02, 8'h07);
		repeat (4) @(negedge clk_sys);
		wr(6'h02, 8'h06);
		cnt = 8'h00;
		repeat (8) @(negedge clk_sys) cnt = cnt + {7'h00, fall};
		chk(cnt, 8'h01);
		stop = 1'b1;
		hold = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({7'h00, poe[2][0]}, 8'h00);
		stop = 1'b0;
		wr(6'h02, 8'h00);
		stop = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({5'h00, poe[2][2:0]}, 8'h06);
		hold = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk({5'h00, poe[2][2:0]}, 8'h00);
		stop = 1'b0;
		dual = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({6'h00, poe[2][2:1]}, 8'h00);
		dual = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk({5'h00, poe[2][2:0]}, 8'h07);
		summarize();
	end
endmodule
